// ---- pll_divider_defs.vh ----
// Constants for the synthesizer programmable divider block.
// Assumes inclusion by the divider module only.
// Function
// - The synthesizer runs only while chip enable is high.
// - The divided input's phase against the reference drives the error pin.
// - One mode setting picks the division method and the AM or FM input.
// - At start the nibbles and swallow low bit load both counters.
// - When the 12-bit counter reaches zero both counters reload.
// - A data write during division takes effect only at the next reload.
// - The data register has no reset and keeps its contents through resets.
// - Both counters are binary down counters starting in the same cycle.
// - The swallow counter is used only in pulse-swallow mode.
// - Divide by 33 while the swallow counter runs, by 32 once it is zero.
// - The data register takes 4-bit and 8-bit accesses only.
// - The division value sits in four nibbles numbered zero to three.
// - Direct mode uses the upper twelve bits, pulse-swallow all sixteen.
// - Method bit zero selects direct AM, one selects pulse-swallow FM.
// - Writing the mode register starts synthesizer operation. The code starts only when the written value has MODE_ENABLE (bit 2) set.
`ifndef PLL_DIVIDER_DEFS_VH
`define PLL_DIVIDER_DEFS_VH
`define ADR_DATA0 4'h0
`define ADR_DATA1 4'h1
`define ADR_DATA2 4'h2
`define ADR_DATA3 4'h3
`define ADR_MODE 4'h4
`define ADR_STAT 4'h5
`define MODE_SWALLOW_LOW 0
`define MODE_ENABLE 2
`define MODE_METHOD 3
`define PRE_MOD33 6'h21
`define PRE_MOD32 6'h20
`define PROG_ZERO 12'h000
`define SWAL_ZERO 5'h00
`endif

// ---- pll_programmable_divider.v ----
// Programmable divider and phase comparator of a frequency synthesizer.
// Assumes oscillator inputs and the reference are slow next to i_clk.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`include "pll_divider_defs.vh"
module pll_programmable_divider (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_chip_enable,
  input wire i_am_oscillator_input,
  input wire i_fm_oscillator_input,
  input wire i_ref_clk,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [0:0] i_wb_sel,
  input wire [7:0] i_wb_dat,
  output wire [7:0] o_wb_dat,
  output wire o_wb_ack,
  output wire o_wb_err,
  output wire o_phase_error_output,
  output wire o_phase_error_oe,
  output wire o_divided_pulse
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when two and three agree.
  reg [2:0] ce_s_r, am_s_r, fm_s_r, rf_s_r;
  reg ce_lv_r, am_lv_r, fm_lv_r, rf_lv_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ce_s_r <= 3'h0;
      am_s_r <= 3'h0;
      fm_s_r <= 3'h0;
      rf_s_r <= 3'h0;
      ce_lv_r <= 1'b0;
      am_lv_r <= 1'b0;
      fm_lv_r <= 1'b0;
      rf_lv_r <= 1'b0;
    end else if (i_ce) begin
      ce_s_r <= {ce_s_r[1:0], i_chip_enable};
      am_s_r <= {am_s_r[1:0], i_am_oscillator_input};
      fm_s_r <= {fm_s_r[1:0], i_fm_oscillator_input};
      rf_s_r <= {rf_s_r[1:0], i_ref_clk};
      if (ce_s_r[1] == ce_s_r[2]) ce_lv_r <= ce_s_r[2];
      if (am_s_r[1] == am_s_r[2]) am_lv_r <= am_s_r[2];
      if (fm_s_r[1] == fm_s_r[2]) fm_lv_r <= fm_s_r[2];
      if (rf_s_r[1] == rf_s_r[2]) rf_lv_r <= rf_s_r[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode. The data bus is 8 bits wide so each access is one
  // nibble or one byte; a byte access to nibble n below 3 also writes n+1.
  wire req = i_wb_cyc & i_wb_stb;
  reg ack_r;
  wire hit = (i_wb_adr <= `ADR_STAT);
  // Writes land on the edge at which the master samples ack high.
  wire wr = req & ack_r & i_wb_we & hit & i_ce;
  wire wr_byte = wr & i_wb_sel[0] & (i_wb_adr < `ADR_DATA3);
  assign o_wb_ack = req & ack_r & hit;
  assign o_wb_err = req & ack_r & ~hit;

  // Acknowledge one cycle after the request, drop it the cycle after.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ack_r <= 1'b0;
    else if (i_ce) ack_r <= req & ~ack_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // Data nibbles carry no reset so they survive every reset kind.
  reg [3:0] nib_r [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_nib
      always @(posedge i_clk) begin
        if (wr && i_wb_adr == g) nib_r[g] <= i_wb_dat[3:0];
        else if (wr_byte && i_wb_adr == g - 1)
          nib_r[g] <= i_wb_dat[7:4];
      end
    end
  endgenerate
  wire [15:0] data_word = {nib_r[3], nib_r[2], nib_r[1], nib_r[0]};

  //////////////////////////////////////////////////////////////////////////
  // Mode register and start request.
  reg [3:0] mode_r;
  reg start_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= 4'h0;
      start_r <= 1'b0;
    end else if (i_ce) begin
      start_r <= 1'b0;
      if (wr && i_wb_adr == `ADR_MODE) begin
        mode_r <= i_wb_dat[3:0];
        start_r <= 1'b1;
      end
    end
  end
  wire fm_mode = mode_r[`MODE_METHOD];
  wire run_en = mode_r[`MODE_ENABLE] & ce_lv_r;

  //////////////////////////////////////////////////////////////////////////
  // Input selection and edge detect on the chosen oscillator.
  wire osc_lv = fm_mode ? fm_lv_r : am_lv_r;
  reg osc_d_r, ce_d_r, rf_d_r;
  wire osc_edge = osc_lv & ~osc_d_r;
  wire ce_rise = ce_lv_r & ~ce_d_r;

  //////////////////////////////////////////////////////////////////////////
  // Counters: prescaler, swallow and programmable.
  reg [5:0] pre_r;
  reg [4:0] swal_r;
  reg [11:0] prog_r;
  reg load_r, div_r;
  wire pre_tick = fm_mode ? (osc_edge && pre_r == 6'h00) : osc_edge;
  wire swal_run = fm_mode && swal_r != `SWAL_ZERO;
  wire [5:0] pre_mod = swal_run ? `PRE_MOD33 : `PRE_MOD32;
  wire [11:0] load_prog = fm_mode ? data_word[15:4] : data_word[15:4];
  wire [4:0] load_swal = fm_mode ?
    {data_word[3:0], mode_r[`MODE_SWALLOW_LOW]} : `SWAL_ZERO;

  // Counting stops while disabled; a start or enable return loads fresh.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_d_r <= 1'b0;
      ce_d_r <= 1'b0;
      pre_r <= 6'h00;
      swal_r <= 5'h00;
      prog_r <= 12'h000;
      load_r <= 1'b0;
      div_r <= 1'b0;
    end else if (i_ce) begin
      osc_d_r <= osc_lv;
      ce_d_r <= ce_lv_r;
      div_r <= 1'b0;
      if (run_en && load_r) begin
        prog_r <= load_prog;
        swal_r <= load_swal;
        pre_r <= `PRE_MOD33 - 6'h01;
        load_r <= 1'b0;
      end else if (run_en && osc_edge) begin
        if (fm_mode) pre_r <= (pre_r == 6'h00) ? pre_mod - 6'h01 :
          pre_r - 6'h01;
        if (pre_tick) begin
          if (prog_r == `PROG_ZERO || prog_r == 12'h001) begin
            prog_r <= load_prog;
            swal_r <= load_swal;
            div_r <= 1'b1;
          end else begin
            prog_r <= prog_r - 12'h001;
            if (swal_run) swal_r <= swal_r - 5'h01;
          end
        end
      end
      // Placed last so a new load request wins over a load in progress.
      if (start_r || ce_rise || !run_en) load_r <= 1'b1;
    end
  end
  assign o_divided_pulse = div_r;

  //////////////////////////////////////////////////////////////////////////
  // Phase comparator: a tri-state output driven high after the divided
  // pulse leads the reference, low after the reference leads.
  reg up_r, dn_r;
  wire ref_edge = rf_lv_r & ~rf_d_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rf_d_r <= 1'b0;
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end else if (i_ce) begin
      rf_d_r <= rf_lv_r;
      if (!run_en) begin
        up_r <= 1'b0;
        dn_r <= 1'b0;
      end else if (div_r && ref_edge) begin
        up_r <= 1'b0;
        dn_r <= 1'b0;
      end else if (div_r) begin
        if (dn_r) dn_r <= 1'b0;
        else up_r <= 1'b1;
      end else if (ref_edge) begin
        if (up_r) up_r <= 1'b0;
        else dn_r <= 1'b1;
      end
    end
  end
  assign o_phase_error_output = up_r;
  assign o_phase_error_oe = up_r | dn_r;

  //////////////////////////////////////////////////////////////////////////
  // Read mux: nibbles, mode and status with swallow run, run enable and enable level.
  reg [7:0] rd_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) rd_r <= 8'h00;
    else if (i_ce && req && !ack_r) begin
      case (i_wb_adr)
        `ADR_DATA0: rd_r <= {nib_r[1], nib_r[0]};
        `ADR_DATA1: rd_r <= {nib_r[2], nib_r[1]};
        `ADR_DATA2: rd_r <= {nib_r[3], nib_r[2]};
        `ADR_DATA3: rd_r <= {4'h0, nib_r[3]};
        `ADR_MODE: rd_r <= {4'h0, mode_r};
        `ADR_STAT: rd_r <= {5'h00, swal_run, run_en, ce_lv_r};
        default: rd_r <= 8'h00;
      endcase
    end
  end
  assign o_wb_dat = rd_r;
endmodule

// ---- pll_div_sva.sv ----
// Bus and pin checks for the synthesizer divider.
// Assumes a bind onto the divider top module.
`timescale 1ns/1ns
module pll_div_sva (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_ce,
  input wire i_chip_enable,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire [3:0] i_wb_adr,
  input wire o_wb_ack,
  input wire o_wb_err,
  input wire o_phase_error_oe,
  input wire o_divided_pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Eight cycles covers the enable synchroniser and the output register.
  sequence ce_off_s;
    !i_chip_enable [*8];
  endsequence
  AST_ANSWER: assert property ($rose(i_wb_cyc && i_wb_stb) && i_ce
    |=> o_wb_ack || o_wb_err) else $error("no answer");
  AST_MAPPED: assert property ($rose(i_wb_cyc && i_wb_stb) && i_ce
    && i_wb_adr < 4'h6 |=> o_wb_ack) else $error("mapped not acked");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held");
  AST_ACK_REQ: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  AST_ERR_ADR: assert property (o_wb_err |-> $past(i_wb_adr) > 4'h5)
    else $error("bad error");
  AST_CE_OE: assert property (ce_off_s |-> !o_phase_error_oe)
    else $error("driving while disabled");
  AST_CE_STOP: assert property (ce_off_s |-> !o_divided_pulse)
    else $error("counting while disabled");
  AST_PULSE: assert property (o_divided_pulse |=>
    !o_divided_pulse [*2]) else $error("pulse too long");
endmodule
bind pll_programmable_divider pll_div_sva u_sva (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_ce(i_ce), .i_chip_enable(i_chip_enable),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_adr(i_wb_adr),
  .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err),
  .o_phase_error_oe(o_phase_error_oe), .o_divided_pulse(o_divided_pulse));

// ---- osc_model.sv ----
// Oscillator model driving the divider's AM and FM inputs.
// Assumes the unselected pin is pulled down.
`timescale 1ns/1ns
module osc_model (
  input wire fm_sel,
  output logic o_am,
  output logic o_fm,
  output int n_edges
);
  logic ph = 1'b0;
  // A 10 MHz tone stays slow enough for the input synchronisers.
  always #50 ph = ~ph;
  assign o_am = ph & !fm_sel;
  assign o_fm = ph & fm_sel;
  // Rising edges are counted so periods can be measured in input edges.
  initial n_edges = 0;
  always @(posedge ph) n_edges++;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the synthesizer divider.
// Assumes the checker and the oscillator model compile first.
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 1'b0, i_rst_n = 1'b0, chip_en = 1'b0, fm_sel = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] dat = 8'h00, rd, q;
  logic ack, err, oe, peo, pulse, am, fm, last_err, ref_c = 1'b0;
  int num_errors = 0, checked = 0, snap, n0, e, n_edges;
  always #5 i_clk = ~i_clk;
  pll_programmable_divider u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(1'b1), .i_chip_enable(chip_en), .i_am_oscillator_input(am),
    .i_fm_oscillator_input(fm), .i_ref_clk(ref_c), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(dat), .o_wb_dat(rd), .o_wb_ack(ack), .o_wb_err(err),
    .o_phase_error_output(peo), .o_phase_error_oe(oe),
    .o_divided_pulse(pulse));
  osc_model u_osc (.fm_sel(fm_sel), .o_am(am), .o_fm(fm),
    .n_edges(n_edges));
  //////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x) begin
      $display("wrong value %s exp %h got %h", nm, x, g);
      num_errors++;
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hang counts once as a mismatch, then the run closes.
  task fail(input string nm);
    chk(nm, 16'h0001, 16'h0000);
    print_verdict;
  endtask
  // Classic single cycle, held until ack or err is sampled high.
  task wb(input logic w, input logic [3:0] a, input logic s,
          input logic [7:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    // Answers are looked at mid-cycle, where they have settled.
    do begin
      @(negedge i_clk);
      n++;
    end while (!(ack || err) && n < 20);
    if (n >= 20) fail("bus");
    q = rd;
    last_err = err;
    @(posedge i_clk);
    {cyc, stb} <= 2'b00;
    @(posedge i_clk);
  endtask
  task setd(input logic [15:0] v);
    wb(1'b1, 4'h0, 1'b1, v[7:0]);
    wb(1'b1, 4'h2, 1'b1, v[15:8]);
  endtask
  // Waits for a division pulse and notes the input edge count there.
  task wp;
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (pulse !== 1'b1 && n < 8000);
    if (n >= 8000) fail("pulse");
    snap = n_edges;
  endtask
  task per(output int p);
    wp;
    n0 = snap;
    wp;
    p = snap - n0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_regs;
    setd(16'h0100);
    wb(1'b1, 4'h1, 1'b0, 8'h5A);
    wb(1'b0, 4'h0, 1'b1, 8'h00);
    chk("byte0", 16'h00A0, 16'(q));
    wb(1'b1, 4'h3, 1'b1, 8'hC7);
    wb(1'b0, 4'h2, 1'b1, 8'h00);
    chk("byte2", 16'h0071, 16'(q));
    wb(1'b0, 4'h9, 1'b1, 8'h00);
    chk("unmapped", 16'h0001, 16'(last_err));
    $display("t_regs done");
  endtask
  task t_am;
    setd(16'h0100);
    wb(1'b1, 4'h4, 1'b0, 8'h04);
    per(e);
    chk("am_n", 16'd16, 16'(e));
    n0 = snap;
    setd(16'h0200);
    wp;
    chk("deferred", 16'd16, 16'(snap - n0));
    n0 = snap;
    wp;
    chk("reload", 16'd32, 16'(snap - n0));
    chk("oe_on", 16'h0001, 16'(oe));
    chk("peo_high", 16'h0001, 16'(peo));
    // A reference edge after the divided pulse leaves the pin floating.
    @(posedge i_clk);
    ref_c <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk("oe_equal", 16'h0000, 16'(oe));
    ref_c <= 1'b0;
    repeat (8) @(posedge i_clk);
    ref_c <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk("oe_ref_lead", 16'h0001, 16'(oe));
    chk("peo_low", 16'h0000, 16'(peo));
    ref_c <= 1'b0;
    $display("t_am done");
  endtask
  task t_fm;
    fm_sel <= 1'b1;
    setd(16'h0103);
    wb(1'b1, 4'h4, 1'b0, 8'h0D);
    per(e);
    chk("fm_n", 16'd519, 16'(e));
    $display("t_fm done");
  endtask
  // Data must survive both a chip-enable drop and an external reset.
  task t_ce;
    chip_en <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk("oe_off", 16'h0000, 16'(oe));
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chip_en <= 1'b1;
    @(posedge i_clk);
    wb(1'b1, 4'h4, 1'b0, 8'h0D);
    per(e);
    chk("kept", 16'd519, 16'(e));
    $display("t_ce done");
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chip_en <= 1'b1;
    @(posedge i_clk);
    t_regs;
    t_am;
    t_fm;
    t_ce;
    print_verdict;
  end
endmodule
